//--- design/smsp_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module smsp_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 32
) (
   input  wire logic         clk_sys_i,
   input  wire logic         rst_i,
   input  wire logic         in_valid_i,
   input  wire logic [W-1:0] in_data_i,
   output logic              in_ready_o,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0]  mem_r [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0]   cnt_r, cnt_nxt;
   logic          full_r, full_nxt, empty_r, empty_nxt;
   logic          push, pop;

   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
         $error("smsp_fifo: DEPTH must be a power of two, at least 2");
   end

   // Flags are registered so the ready and valid ports are clean
   always_comb
   begin
      push      = in_valid_i & ~full_r;
      pop       = out_ready_i & ~empty_r;
      wp_nxt    = push ? wp_r + 1'b1 : wp_r;
      rp_nxt    = pop ? rp_r + 1'b1 : rp_r;
      cnt_nxt   = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      full_nxt  = cnt_nxt == (AW+1)'(DEPTH);
      empty_nxt = cnt_nxt == '0;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         wp_r    <= '0;
         rp_r    <= '0;
         cnt_r   <= '0;
         full_r  <= 1'b0;
         empty_r <= 1'b1;
      end
      else
      begin
         wp_r    <= wp_nxt;
         rp_r    <= rp_nxt;
         cnt_r   <= cnt_nxt;
         full_r  <= full_nxt;
         empty_r <= empty_nxt;
      end
      if (push)
         mem_r[wp_r] <= in_data_i;
   end

   assign in_ready_o  = ~full_r;
   assign out_valid_o = ~empty_r;
   assign out_data_o  = mem_r[rp_r];
endmodule // smsp_fifo
`default_nettype wire

//--- design/smsp_port.sv
// Byte-wide SPI port, master or slave, with transmit stream FIFO
// Function
// RL1: Master lowers slave select before clocking
// RL2: MOSI master to slave, MISO back, together
// RL3: Master raises slave select after each packet
// RL4: Master mode never drives slave select itself
// RL5: Master data write starts eight-bit shift
// RL6: After byte, SCK stops, done flag sets
// RL7: Done flag with enable raises interrupt
// RL8: Last received byte stays in buffer
// RL9: Deselected slave idles, MISO not driven
// RL10: Deselected slave accepts writes, ignores SCK
// RL11: Slave byte sets done flag, interrupt
// RL12: Slave may load next byte before reading
// RL13: Transmit single buffered, no write mid-shift
// RL14: Receive double buffered, unread byte overwritten
// RL15: External SCK at most quarter system clock
// RL16: Enabled port overrides pin directions by mode
// RL17: LSB or MSB first selectable
// RL18: Seven rates including divide by two
// RL19: Done event wakes device from idle
// RL20: Collision flag on busy write, cleared sequence
// RL21: Done cleared by vector or status-data sequence
// RL22: Low select input demotes master, sets done
// RL23: Select high resets slave, drops partial bits
// RL24: Receive buffer loads with done flag
// RL25: Disabled port shifts nothing, drives nothing
`timescale 1ns/100ps
`default_nettype none
module smsp_port #(
   parameter int FIFO_DEPTH = 32
) (
   input  wire logic                  clk_sys_i,
   input  wire logic                  rst_i,
   input  wire smsp_pkg::smsp_cfg_t   cfg_i,
   input  wire smsp_pkg::smsp_dir_t   dir_i,
   input  wire logic                  master_set_i,
   input  wire logic                  data_wr_i,
   input  wire logic [7:0]            data_wd_i,
   input  wire logic                  data_rd_i,
   input  wire logic                  status_rd_i,
   input  wire logic                  irq_ack_i,
   input  wire logic                  tx_valid_i,
   input  wire logic [7:0]            tx_data_i,
   output logic                       tx_ready_o,
   input  wire logic                  sck_i,
   output logic                       sck_o,
   output logic                       sck_oe_o,
   input  wire logic                  mosi_i,
   output logic                       mosi_o,
   output logic                       mosi_oe_o,
   input  wire logic                  miso_i,
   output logic                       miso_o,
   output logic                       miso_oe_o,
   input  wire logic                  ss_n_i,
   output logic [7:0]                 rx_data_o,
   output logic                       xfer_done_flag_o,
   output logic                       write_collision_flag_o,
   output logic                       master_select_bit_o,
   output logic                       irq_o,
   output logic                       wake_o
);
   import smsp_pkg::*;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   smsp_state_t state_r, state_nxt;
   logic [7:0]  shreg_r, shreg_nxt, rxbuf_r, rxbuf_nxt, shifted;
   logic [3:0]  edge_r, edge_nxt;
   logic [5:0]  div_r, div_nxt, half;
   logic        sck_r, sck_nxt, out_r, out_nxt;
   logic        done_r, done_nxt, write_collision_flag_r, write_collision_flag_nxt, arm_r, arm_nxt;
   logic        master_r, master_nxt, irq_r, irq_nxt;
   logic        sck_oe_r, sck_oe_nxt, mosi_oe_r, mosi_oe_nxt;
   logic        miso_oe_r, miso_oe_nxt;
   logic [3:0]  sy1_r, sy2_r;
   logic        sck_d_r;
   logic        ss_low, sck_s, lead, trail, sample, in_bit;
   logic        tick, last_m, demote, fifo_valid, fifo_pop;
   logic [7:0]  fifo_data;
   logic [7:0]  mrx_r, mrx_nxt;
   logic [1:0]  sd_r, sd_nxt;

   // Transmit stream; drained only by an idle master
   smsp_fifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys_i   (clk_sys_i),
      .rst_i       (rst_i),
      .in_valid_i  (tx_valid_i),
      .in_data_i   (tx_data_i),
      .in_ready_o  (tx_ready_o),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_data)
   );

   // Pin synchronisers: order sck, mosi, miso, select
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         sy1_r   <= 4'hF;
         sy2_r   <= 4'hF;
         sck_d_r <= 1'b0;
      end
      else
      begin
         sy1_r   <= {sck_i, mosi_i, miso_i, ss_n_i};
         sy2_r   <= sy1_r;
         sck_d_r <= sy2_r[3];
      end
   end

   // Rate table, master only; slave SCK must stay under a quarter clock
   always_comb
   begin
      case ({cfg_i.dbl, cfg_i.rate})                       // RL18
         3'h0:    half = HALF_D4;
         3'h1:    half = HALF_D16;
         3'h2:    half = HALF_D64;
         3'h3:    half = HALF_D128;
         3'h4:    half = HALF_D2;
         3'h5:    half = HALF_D8;
         3'h6:    half = HALF_D32;
         default: half = HALF_D64;
      endcase
   end

   // Edge detection and bit selection shared by both modes
   always_comb
   begin
      ss_low  = ~sy2_r[0];
      sck_s   = sy2_r[3];
      lead    = (sck_s != sck_d_r) && (sck_d_r == cfg_i.cpol);
      trail   = (sck_s != sck_d_r) && (sck_d_r != cfg_i.cpol);
      in_bit  = master_r ? sy2_r[1] : sy2_r[2];              // RL2
      tick    = state_r == ST_MRUN && div_r == half - 6'h01;
      sample  = master_r ? (tick && edge_r[0] == cfg_i.cpha)
                         : (cfg_i.cpha ? trail : lead);
      shifted = cfg_i.lsb_first ? {in_bit, shreg_r[7:1]}     // RL17
                                : {shreg_r[6:0], in_bit};
      last_m  = tick && edge_r == EDGE_LAST;
      demote  = cfg_i.enable && master_r && !dir_i.ss && ss_low;
      fifo_pop = cfg_i.enable && master_r && state_r == ST_IDLE
                 && !data_wr_i && !demote;
   end

   // Core sequencer, flags and pin enables
   always_comb
   begin
      state_nxt  = state_r;
      shreg_nxt  = shreg_r;
      rxbuf_nxt  = rxbuf_r;
      edge_nxt   = edge_r;
      div_nxt    = div_r;
      sck_nxt    = sck_r;
      done_nxt   = done_r;
      write_collision_flag_nxt   = write_collision_flag_r;
      arm_nxt    = arm_r;
      master_nxt = master_r | master_set_i;
      // Master MISO bits land two clocks late, matching the pin sync
      sd_nxt     = {sd_r[0], master_r && sample};
      mrx_nxt    = mrx_r;
      if (sd_r[1])
         mrx_nxt = cfg_i.lsb_first ? {sy2_r[1], mrx_r[7:1]}
                                   : {mrx_r[6:0], sy2_r[1]};
      // Status read with a flag up arms; next data access clears
      if (status_rd_i && (done_r || write_collision_flag_r))
         arm_nxt = 1'b1;
      if ((data_rd_i || data_wr_i) && arm_r)
      begin
         done_nxt = 1'b0;                                    // RL21
         write_collision_flag_nxt = 1'b0;                                    // RL20
         arm_nxt  = 1'b0;
      end
      if (irq_ack_i)
         done_nxt = 1'b0;                                    // RL21
      // Write goes to the shifter only in ST_IDLE: master between bytes, slave deselected
      if (data_wr_i)
      begin
         if (state_r != ST_IDLE)
            write_collision_flag_nxt = 1'b1;                                 // RL13
         else
            shreg_nxt = data_wd_i;                           // RL10 RL12
      end
      else if (fifo_pop && fifo_valid)
         shreg_nxt = fifo_data;
      if (!cfg_i.enable)
      begin
         state_nxt = ST_IDLE;                                // RL25
         edge_nxt  = EDGE_ZERO;
         sck_nxt   = cfg_i.cpol;
      end
      else if (demote)
      begin
         master_nxt = 1'b0;                                  // RL22
         done_nxt   = 1'b1;
         state_nxt  = ST_IDLE;
         edge_nxt   = EDGE_ZERO;
      end
      else if (master_r)
      begin
         if (state_r == ST_IDLE)
         begin
            sck_nxt = cfg_i.cpol;
            if (data_wr_i || (fifo_pop && fifo_valid))
            begin
               state_nxt = ST_MRUN;                          // RL5
               edge_nxt  = EDGE_ZERO;
               div_nxt   = DIV_ZERO;
            end
         end
         else if (state_r == ST_MTAIL)
         begin
            div_nxt = div_r + 6'h01;
            if (div_r == TAIL_LAST)
            begin
               state_nxt = ST_IDLE;                          // RL6
               done_nxt  = 1'b1;
               rxbuf_nxt = mrx_nxt;                          // RL24 RL8
            end
         end
         else
         begin
            div_nxt = tick ? DIV_ZERO : div_r + 6'h01;
            if (tick)
            begin
               sck_nxt  = ~sck_r;
               edge_nxt = edge_r + 4'h1;
               if (sample)
                  shreg_nxt = shifted;
            end
            if (last_m)
            begin
               state_nxt = ST_MTAIL;                         // RL6
               div_nxt   = DIV_ZERO;
            end
         end
      end
      else if (!ss_low)
      begin
         state_nxt = ST_IDLE;                                // RL23 RL9
         edge_nxt  = EDGE_ZERO;
      end
      else
      begin
         state_nxt = ST_SRUN;
         if (sample)
         begin
            shreg_nxt = shifted;
            edge_nxt  = {1'b0, edge_r[2:0] + 3'h1};
            if (edge_r[2:0] == BIT_LAST)
            begin
               done_nxt  = 1'b1;                             // RL11
               rxbuf_nxt = shifted;                          // RL14 RL24
               edge_nxt  = EDGE_ZERO;
            end
         end
      end
      // Master holds its data bit across the sample edge, moves one clock after it
      if (master_r && sample)
         out_nxt = out_r;
      else
         out_nxt = cfg_i.lsb_first ? shreg_nxt[0] : shreg_nxt[7];
      // Master never touches select; user directions apply
      sck_oe_nxt  = cfg_i.enable && master_nxt && dir_i.sck;  // RL16 RL4
      mosi_oe_nxt = cfg_i.enable && master_nxt && dir_i.mosi; // RL16
      miso_oe_nxt = cfg_i.enable && !master_nxt && ss_low
                    && dir_i.miso;                           // RL16 RL9
      irq_nxt     = done_nxt && cfg_i.irq_en;                // RL7 RL11
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         state_r   <= ST_IDLE;
         shreg_r   <= 8'h00;
         rxbuf_r   <= 8'h00;
         edge_r    <= EDGE_ZERO;
         div_r     <= DIV_ZERO;
         sck_r     <= 1'b0;
         out_r     <= 1'b0;
         done_r    <= 1'b0;
         write_collision_flag_r    <= 1'b0;
         arm_r     <= 1'b0;
         master_r  <= 1'b0;
         irq_r     <= 1'b0;
         sck_oe_r  <= 1'b0;
         mosi_oe_r <= 1'b0;
         miso_oe_r <= 1'b0;
         mrx_r     <= 8'h00;
         sd_r      <= 2'b00;
      end
      else
      begin
         state_r   <= state_nxt;
         shreg_r   <= shreg_nxt;
         rxbuf_r   <= rxbuf_nxt;
         edge_r    <= edge_nxt;
         div_r     <= div_nxt;
         sck_r     <= sck_nxt;
         out_r     <= out_nxt;
         done_r    <= done_nxt;
         write_collision_flag_r    <= write_collision_flag_nxt;
         arm_r     <= arm_nxt;
         master_r  <= master_nxt;
         irq_r     <= irq_nxt;
         sck_oe_r  <= sck_oe_nxt;
         mosi_oe_r <= mosi_oe_nxt;
         miso_oe_r <= miso_oe_nxt;
         mrx_r     <= mrx_nxt;
         sd_r      <= sd_nxt;
      end
   end

   // Slave shifts both directions in one register; master receives into mrx_r
   assign sck_o                  = sck_r;
   assign sck_oe_o               = sck_oe_r;
   assign mosi_o                 = out_r;
   assign mosi_oe_o              = mosi_oe_r;
   assign miso_o                 = out_r;
   assign miso_oe_o              = miso_oe_r;
   assign rx_data_o              = rxbuf_r;
   assign xfer_done_flag_o       = done_r;
   assign write_collision_flag_o = write_collision_flag_r;
   assign master_select_bit_o    = master_r;
   assign irq_o                  = irq_r;
   assign wake_o                 = done_r;                   // RL19

   property p_start;
      cfg_i.enable && master_r && !demote && state_r == ST_IDLE
      && data_wr_i |=> state_r == ST_MRUN && edge_r == EDGE_ZERO;
   endproperty
   a_start: assert property (p_start)                        // RL5
      else $error("master write did not start a byte");

   property p_stop;
      cfg_i.enable && !demote && state_r == ST_MTAIL
      && div_r == TAIL_LAST
      |=> state_r == ST_IDLE && done_r && sck_r == $past(cfg_i.cpol)
          && rx_data_o == mrx_r;
   endproperty
   a_stop: assert property (p_stop)                          // RL6 RL24
      else $error("byte end did not stop clock and load buffer");

   property p_irq;
      $rose(done_r) && $past(cfg_i.irq_en) |-> irq_o;
   endproperty
   a_irq: assert property (p_irq)                            // RL7
      else $error("done flag with enable gave no interrupt");

   property p_miso_off;
      !ss_low || (master_r && !demote) || !cfg_i.enable |=> !miso_oe_o;
   endproperty
   a_miso_off: assert property (p_miso_off)                  // RL9 RL16
      else $error("MISO driven while not a selected slave");

   property p_write_collision_flag;
      data_wr_i && state_r != ST_IDLE |=> write_collision_flag_o;
   endproperty
   a_write_collision_flag: assert property (p_write_collision_flag)                          // RL13 RL20
      else $error("busy write did not raise collision");

   property p_demote;
      demote |=> !master_select_bit_o && xfer_done_flag_o
                 && state_r == ST_IDLE;
   endproperty
   a_demote: assert property (p_demote)                      // RL22
      else $error("select low did not demote master");

   property p_ss_reset;
      cfg_i.enable && !master_r && !ss_low
      |=> state_r == ST_IDLE && edge_r == EDGE_ZERO;
   endproperty
   a_ss_reset: assert property (p_ss_reset)                  // RL23
      else $error("deselected slave kept its bit count");

   property p_off;
      !cfg_i.enable |=> !sck_oe_o && !mosi_oe_o && state_r == ST_IDLE;
   endproperty
   a_off: assert property (p_off)                            // RL25
      else $error("disabled port still active");
endmodule // smsp_port
`default_nettype wire

//--- pkg/smsp_pkg.sv
// Shared constants, carriers and state codes of the SPI master/slave port
package smsp_pkg;
   localparam int          BYTE_W    = 8;
   localparam int          FIFO_D    = 32;
   localparam logic [3:0]  EDGE_LAST = 4'hF;   // 16 SCK edges per byte
   localparam logic [2:0]  BIT_LAST  = 3'h7;   // Slave bit counter end
   localparam logic [2:0]  BIT_ZERO  = 3'h0;
   localparam logic [3:0]  EDGE_ZERO = 4'h0;
   localparam logic [5:0]  DIV_ZERO  = 6'h00;
   // Master tail: clocks after the last edge for MISO through its sync
   localparam logic [5:0]  TAIL_LAST = 6'h01;
   // Half SCK period in system clocks, by {double, rate}
   localparam logic [5:0]  HALF_D4   = 6'h02;
   localparam logic [5:0]  HALF_D16  = 6'h08;
   localparam logic [5:0]  HALF_D64  = 6'h20;
   localparam logic [5:0]  HALF_D128 = 6'h40 - 6'h01 + 6'h01;
   localparam logic [5:0]  HALF_D2   = 6'h01;
   localparam logic [5:0]  HALF_D8   = 6'h04;
   localparam logic [5:0]  HALF_D32  = 6'h10;

   // Configuration bits held by software
   typedef struct packed {
      logic       enable;
      logic       irq_en;
      logic       lsb_first;
      logic       cpol;
      logic       cpha;
      logic       dbl;
      logic [1:0] rate;
   } smsp_cfg_t;

   // User pin directions, 1 = output
   typedef struct packed {
      logic mosi;
      logic miso;
      logic sck;
      logic ss;
   } smsp_dir_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_MRUN = 2'b01,
      ST_SRUN  = 2'b10,
      ST_MTAIL = 2'b11
   } smsp_state_t;
endpackage

//--- sim/smsp_peer.sv
// Far-end SPI model: mode-0 slave plus a master stimulus task
`timescale 1ns/100ps
`default_nettype none
module smsp_peer (
   input  wire logic clk_i,
   input  wire logic lsb_i,
   input  wire logic sel_n_i,
   input  wire logic sck_i,
   input  wire logic mosi_i,
   input  wire logic miso_i,
   output var  logic miso_o,
   output var  logic sck_o,
   output var  logic mosi_o,
   output var  logic ss_n_o
);
   logic [7:0] tx_r  = 8'hA5;
   logic [7:0] sh_r  = 8'h00;
   logic [2:0] cnt_r = 3'h0;
   logic [7:0] rxq[$];

   // Idle levels: clock low, select high
   initial
   begin
      miso_o = 1'b0;
      sck_o  = 1'b0;
      mosi_o = 1'b0;
      ss_n_o = 1'b1;
   end

   function automatic logic pick(input logic [7:0] b, input logic [2:0] i);
      return lsb_i ? b[i] : b[3'h7-i];
   endfunction

   // Slave samples on the rising edge; select high drops a partial count
   always @(posedge sck_i or posedge sel_n_i)
   begin : samp
      logic [7:0] nx;
      nx = lsb_i ? {mosi_i, sh_r[7:1]} : {sh_r[6:0], mosi_i};
      if (sel_n_i)
         cnt_r <= 3'h0;
      else
      begin
         sh_r  <= nx;
         cnt_r <= cnt_r + 3'h1;
         if (cnt_r == 3'h7)
            rxq.push_back(nx);
      end
   end

   // Released line shows the inverse so a stale value cannot pass
   always @(negedge sel_n_i or posedge sel_n_i or negedge sck_i)
      if (sel_n_i)
         miso_o <= ~miso_o;
      else
         miso_o <= pick(tx_r, cnt_r);

   // Master role: six clocks a half period keeps SCK under a quarter rate
   task automatic master_xfer(input logic [7:0] b, input int nb,
                              output logic [7:0] r);
      @(posedge clk_i);
      ss_n_o <= 1'b0;
      for (int i = 0; i < nb; i++)
      begin
         mosi_o <= pick(b, 3'(i));
         repeat (6) @(posedge clk_i);
         sck_o <= 1'b1;
         r = lsb_i ? {miso_i, r[7:1]} : {r[6:0], miso_i};
         repeat (6) @(posedge clk_i);
         sck_o <= 1'b0;
      end
      repeat (6) @(posedge clk_i);
      ss_n_o <= 1'b1;
      mosi_o <= ~mosi_o;
      repeat (6) @(posedge clk_i);
   endtask
endmodule // smsp_peer
`default_nettype wire

//--- sim/smsp_port_test.sv
// Self-checking bench for the SPI master/slave port
`timescale 1ns/100ps
`default_nettype none
module smsp_port_test;
   import smsp_pkg::*;
   logic       clk_sys_i = 1'b0;
   logic       rst_i     = 1'b1;
   smsp_cfg_t  cfg       = '0;
   smsp_dir_t  dir       = '0;
   logic [4:0] stb       = 5'h00;  // set, ack, status, read, write
   logic [7:0] wd        = 8'h00;
   logic       tx_valid  = 1'b0;
   logic [7:0] tx_data   = 8'h00;
   logic       sel_n     = 1'b1;
   logic       tx_ready, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
   logic       p_miso, p_sck, p_mosi, p_ss_n, done, coll, master_select_bit, irq, wake;
   logic [7:0] rx_data;
   int         error_cnt = 0;
   int         samples_checked = 0;
   int         hh[8] = '{2, 8, 32, 64, 1, 4, 16, 32};
   // Wire levels: whoever has its enable up owns the line
   wire logic  sck_w  = sck_oe  ? sck_o  : p_sck;
   wire logic  mosi_w = mosi_oe ? mosi_o : p_mosi;
   wire logic  miso_w = miso_oe ? miso_o : p_miso;

   always #10 clk_sys_i = ~clk_sys_i;

   smsp_port dut (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .cfg_i(cfg), .dir_i(dir),
      .master_set_i(stb[4]), .irq_ack_i(stb[3]), .status_rd_i(stb[2]),
      .data_rd_i(stb[1]), .data_wr_i(stb[0]), .data_wd_i(wd),
      .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready),
      .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe), .mosi_i(mosi_w),
      .mosi_o(mosi_o), .mosi_oe_o(mosi_oe), .miso_i(miso_w),
      .miso_o(miso_o), .miso_oe_o(miso_oe), .ss_n_i(p_ss_n),
      .rx_data_o(rx_data), .xfer_done_flag_o(done),
      .write_collision_flag_o(coll), .master_select_bit_o(master_select_bit),
      .irq_o(irq), .wake_o(wake));

   smsp_peer peer (
      .clk_i(clk_sys_i), .lsb_i(cfg.lsb_first), .sel_n_i(sel_n),
      .sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w), .miso_o(p_miso),
      .sck_o(p_sck), .mosi_o(p_mosi), .ss_n_o(p_ss_n));

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      samples_checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic pulse(input logic [4:0] m);
      @(posedge clk_sys_i);
      stb <= m;
      @(posedge clk_sys_i);
      stb <= 5'h00;
   endtask

   task automatic step;
      @(posedge clk_sys_i);
      #1;
   endtask

   // Bounded wait for the done flag, counting edges after the write
   task automatic wait_done(output int n);
      n = 0;
      do
      begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end while (done !== 1'b1 && n < 1100);
      if (n >= 1100)
      begin
         error_cnt++;
         end_of_test();
      end
   endtask

   // Status read then data read clears the flags
   task automatic clr;
      pulse(5'h04);
      pulse(5'h02);
      step();
   endtask

   task automatic t_reset;
      chk("flags", 16'h0000, {done, coll, master_select_bit, irq, wake});
      chk("oe", 16'h0000, {sck_oe, mosi_oe, miso_oe, sck_o});
      chk("rx_ready", 16'h0001, {rx_data, tx_ready});
      $display("test reset done");
   endtask

   // Writes while deselected wait; two bytes, first one never read
   task automatic t_slave;
      logic [7:0] r;
      cfg <= '{enable: 1'b1, irq_en: 1'b1, default: '0};
      dir <= '{miso: 1'b1, default: '0};
      wd  <= 8'hC3;
      pulse(5'h01);
      repeat (20) step();
      chk("idle", 16'h0000, {done, miso_oe});
      peer.master_xfer(8'h96, 8, r);
      chk("s_tx", 16'h00C3, r);
      chk("s_done", 16'h0003, {done, irq});
      chk("s_rx", 16'h0096, rx_data);
      wd <= 8'h0F;
      pulse(5'h01);
      peer.master_xfer(8'h69, 8, r);
      chk("s_tx2", 16'h000F, r);
      chk("s_rx2", 16'h0069, rx_data);
      clr();
      peer.master_xfer(8'hFF, 4, r);
      chk("part", 16'h0000, done);
      peer.master_xfer(8'h24, 8, r);
      chk("resync", 16'h0024, rx_data);
      clr();
      $display("test slave done");
   endtask

   // One master byte at rate code k, full check of the exchange
   task automatic mxfer(input logic [7:0] b, input int k);
      int n;
      cfg.dbl <= k[2];
      cfg.rate <= k[1:0];
      cfg.lsb_first <= k[0];
      peer.tx_r = ~b;
      sel_n <= 1'b0;
      wd <= b;
      pulse(5'h01);
      wait_done(n);
      chk("cycles", 16'(16 * hh[k] + 2), 16'(n));
      chk("sck_idle", 16'h0000, sck_o);
      chk("irq", 16'h0003, {irq, wake});
      chk("oe", 16'h0005, {sck_oe, miso_oe, mosi_oe});
      chk("m_rx", {8'h00, ~b}, rx_data);
      chk("far_rx", 16'(b), peer.rxq.pop_front());
      sel_n <= 1'b1;
      clr();
      chk("clr", 16'h0000, {done, irq});
   endtask

   task automatic t_master;
      int n;
      dir <= '{mosi: 1'b1, sck: 1'b1, default: '0};
      pulse(5'h10);
      for (int k = 0; k < 8; k++)
         mxfer(8'(8'h5A + k), k);
      peer.tx_r = 8'h11;
      sel_n <= 1'b0;
      wd <= 8'hC6;
      pulse(5'h01);
      wd <= 8'h39;
      pulse(5'h01);
      wait_done(n);
      chk("coll", 16'h0001, coll);
      chk("kept", 16'h00C6, peer.rxq.pop_front());
      clr();
      chk("coll_clr", 16'h0000, {coll, done});
      pulse(5'h01);
      wait_done(n);
      pulse(5'h08);
      step();
      chk("ack", 16'h0000, {done, irq});
      sel_n <= 1'b1;
      $display("test master done");
   endtask

   // Fill the FIFO while disabled, then let the master drain it
   task automatic t_fifo;
      int n;
      cfg.enable <= 1'b0;
      peer.rxq.delete();
      n = 0;
      tx_valid <= 1'b1;
      tx_data <= 8'h40;
      repeat (40)
      begin
         @(posedge clk_sys_i);
         if (tx_ready === 1'b1)
         begin
            n++;
            tx_data <= 8'(8'h40 + n);
         end
      end
      tx_valid <= 1'b0;
      chk("fill", 16'd32, 16'(n));
      chk("off", 16'h0000, {sck_oe, 8'(peer.rxq.size())});
      cfg <= '{enable: 1'b1, dbl: 1'b1, default: '0};
      sel_n <= 1'b0;
      for (n = 0; n < 3000 && peer.rxq.size() < 32; n++)
         step();
      for (int i = 0; i < 32; i++)
         chk("stream", 16'(8'h40 + i), peer.rxq.pop_front());
      sel_n <= 1'b1;
      clr();
      $display("test fifo done");
   endtask

   // Select input pulled low while master: port falls back to slave
   task automatic t_demote;
      logic [7:0] r;
      peer.master_xfer(8'h00, 0, r);
      chk("demote", 16'h0001, {master_select_bit, done});
      $display("test demote done");
   endtask

   // Main sequence
   initial
   begin
      repeat (12) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      step();
      t_reset();
      t_slave();
      t_master();
      t_fifo();
      t_demote();
      end_of_test();
   end
endmodule // smsp_port_test
`default_nettype wire
